// ==== rtl/dsw_defines.svh ====
// Constants of the deep standby wake-up controller: register indices,
// field positions, reset values and counts.
// Assumes inclusion by bare name from the design top and the testbench.
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH

// Register indices; byte address on the bus is four times the index
`define DSW_IDX_PIN_SEL 24'hfffbcc
`define DSW_IDX_CLK_RATIO 24'hfffdc4
`define DSW_IDX_STBY_CTRL 24'hfffdc6
`define DSW_IDX_DEEP_CTRL 24'hfffe70
`define DSW_IDX_SETTLE 24'hfffe71
`define DSW_IDX_WAKE_EN 24'hfffe72
`define DSW_IDX_WAKE_FLAGS 24'hfffe73
`define DSW_IDX_WAKE_EDGE 24'hfffe74
`define DSW_IDX_RST_CAUSE 24'hfffe75
`define DSW_IDX_IRQ_STATUS 24'hfff000
`define DSW_IDX_IRQ_MASK 24'hfff001

// Field positions
`define DSW_BIT_PIN_SEL 0
`define DSW_BIT_SOFT_STBY 15
`define DSW_BIT_DEEP_STBY 7
`define DSW_BIT_PORT_HOLD 6
`define DSW_BIT_WAKE_EN 0
`define DSW_BIT_WAKE_FLAG 0
`define DSW_BIT_WAKE_EDGE 0
`define DSW_BIT_RST_FLAG 7
`define DSW_BIT_IRQ_WAKE 0
`define DSW_BIT_IRQ_ENTER 1

// Reset values
`define DSW_RST_CLK_RATIO 16'h0010
`define DSW_RST_SETTLE 6'h0d

// Ratio encodings and multipliers
`define DSW_RATIO_X4 3'h0
`define DSW_RATIO_X2 3'h1
`define DSW_RATIO_X1 3'h2

// Timing: settle code that selects the long wait, its length in states
`define DSW_SETTLE_LONG_CODE 6'h0d
`define DSW_SETTLE_LONG_STATES 131072
`define DSW_SETTLE_SHORT_STATES 1024
`define DSW_INTRST_CYCLES 4'h4

`endif

// ==== rtl/dsw_pkg.sv ====
// Types of the deep standby wake-up controller.
// Assumes the constants header is compiled alongside.
package dsw_pkg;

  // Controller states
  typedef enum logic [1:0] {
    DSW_RUN    = 2'b00,
    DSW_DEEP   = 2'b01,
    DSW_SETTLE = 2'b10,
    DSW_INTRST = 2'b11
  } dsw_state_t;

  // Clock ratio control register layout
  typedef struct packed {
    logic       bus_clk_pin_gate;
    logic       sdram_clk_pin_gate;
    logic [2:0] rsv_hi;
    logic [2:0] core_clk_ratio;
    logic       rsv_mid;
    logic [2:0] periph_clk_ratio;
    logic       rsv_lo;
    logic [2:0] extbus_clk_ratio;
  } dsw_clk_ratio_t;

  // Captured bus address phase
  typedef struct packed {
    logic        active;
    logic        write;
    logic [31:0] addr;
  } dsw_bus_req_t;

endpackage : dsw_pkg

// ==== rtl/dsw_top.sv ====
// Deep standby wake-up controller: standby entry, wake-up detection,
// clock settle wait, internal reset, port retention and clock setup.
// Assumes an AHB-Lite master on CLK, pin inputs asynchronous to CLK,
// and sleep/cancel/port inputs generated on CLK.
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defines.svh"

module dsw_top #(
  parameter int PORT_W = 8,
  parameter int SETTLE_LONG = `DSW_SETTLE_LONG_STATES,
  parameter int SETTLE_SHORT = `DSW_SETTLE_SHORT_STATES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic IRQ_PIN_A,
  input wire logic IRQ_PIN_B,
  input wire logic SLEEP_REQ,
  input wire logic CANCEL_PENDING,
  input wire logic [PORT_W-1:0] PORT_IN,
  output logic [PORT_W-1:0] PORT_OUT,
  output logic PORT_HOLD,
  output logic DEEP_STANDBY,
  output logic INT_RESET,
  output logic BUS_CLK_PIN,
  output logic SDRAM_CLK_PIN,
  output logic [2:0] CORE_CLK_MULT,
  output logic [2:0] PERIPH_CLK_MULT,
  output logic [2:0] EXTBUS_CLK_MULT,
  output logic IRQ
);

  // Multiplier for a ratio code; unlisted codes report zero
  function automatic logic [2:0] ratio_mult(input logic [2:0] code);
    case (code)
      `DSW_RATIO_X4: ratio_mult = 3'h4;
      `DSW_RATIO_X2: ratio_mult = 3'h2;
      `DSW_RATIO_X1: ratio_mult = 3'h1;
      default: ratio_mult = 3'h0;
    endcase
  endfunction : ratio_mult

  // True when a byte address hits a register index
  function automatic logic hit(input logic [31:0] addr, input logic [23:0] idx);
    hit = (addr == {6'h00, idx, 2'b00});
  endfunction : hit

  dsw_pkg::dsw_state_t state_q;
  dsw_pkg::dsw_bus_req_t req_q;
  dsw_pkg::dsw_clk_ratio_t clk_ratio_q;
  logic hready_q;
  logic [31:0] rdata_q;
  logic pin_sel_q;
  logic soft_stby_q;
  logic deep_stby_q;
  logic port_hold_keep_q;
  logic [5:0] settle_q;
  logic wake_en_q;
  logic wake_edge_q;
  logic wake_flag_q;
  logic wake_flag_armed_q;
  logic rst_flag_q;
  logic rst_flag_armed_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic irq_q;
  logic [1:0] sync_a_q;
  logic [1:0] sync_b_q;
  logic irq_prev_q;
  logic [17:0] settle_cnt_q;
  logic [3:0] intrst_cnt_q;
  logic hold_q;
  logic [PORT_W-1:0] hold_val_q;
  logic [PORT_W-1:0] port_out_q;
  logic clk_div_q;
  logic bus_pin_q;
  logic sdram_pin_q;
  logic [2:0] core_mult_q;
  logic [2:0] periph_mult_q;
  logic [2:0] extbus_mult_q;
  logic deep_out_q;
  logic intrst_out_q;

  logic addr_take;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_mux;
  logic irq_sel;
  logic edge_hit;
  logic wake_ev;
  logic enter_ev;
  logic settle_done;
  logic [17:0] settle_len;

  // Address phase taken only while the bus is ready
  assign addr_take = HSEL && HTRANS[1] && HREADY;
  // Data phase completes at the edge after the wait state
  assign wr_en = req_q.active && req_q.write;
  assign rd_en = req_q.active && !req_q.write;

  // One wait state on every transfer: writes land before the next
  // address is accepted, so a read never sees stale contents
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      req_q <= '0;
      hready_q <= 1'b1;
    end else begin
      if (addr_take) begin
        req_q <= '{active: 1'b1, write: HWRITE, addr: HADDR};
        hready_q <= 1'b0;
      end else begin
        req_q.active <= 1'b0;
        hready_q <= 1'b1;
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(req_q.addr, `DSW_IDX_PIN_SEL)) begin
      rd_mux[`DSW_BIT_PIN_SEL] = pin_sel_q;
    end else if (hit(req_q.addr, `DSW_IDX_CLK_RATIO)) begin
      rd_mux[15:0] = clk_ratio_q;
    end else if (hit(req_q.addr, `DSW_IDX_STBY_CTRL)) begin
      rd_mux[`DSW_BIT_SOFT_STBY] = soft_stby_q;
    end else if (hit(req_q.addr, `DSW_IDX_DEEP_CTRL)) begin
      rd_mux[`DSW_BIT_DEEP_STBY] = deep_stby_q;
      rd_mux[`DSW_BIT_PORT_HOLD] = port_hold_keep_q;
    end else if (hit(req_q.addr, `DSW_IDX_SETTLE)) begin
      rd_mux[5:0] = settle_q;
    end else if (hit(req_q.addr, `DSW_IDX_WAKE_EN)) begin
      rd_mux[`DSW_BIT_WAKE_EN] = wake_en_q;
    end else if (hit(req_q.addr, `DSW_IDX_WAKE_FLAGS)) begin
      rd_mux[`DSW_BIT_WAKE_FLAG] = wake_flag_q;
    end else if (hit(req_q.addr, `DSW_IDX_WAKE_EDGE)) begin
      rd_mux[`DSW_BIT_WAKE_EDGE] = wake_edge_q;
    end else if (hit(req_q.addr, `DSW_IDX_RST_CAUSE)) begin
      rd_mux[`DSW_BIT_RST_FLAG] = rst_flag_q;
    end else if (hit(req_q.addr, `DSW_IDX_IRQ_STATUS)) begin
      rd_mux[1:0] = irq_stat_q;
    end else if (hit(req_q.addr, `DSW_IDX_IRQ_MASK)) begin
      rd_mux[1:0] = irq_mask_q;
    end
  end

  // Read data registered at the end of the wait state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_q <= rd_mux;
    end
  end

  // Plain control registers written by software
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_sel_q <= 1'b0;
      soft_stby_q <= 1'b0;
      deep_stby_q <= 1'b0;
      port_hold_keep_q <= 1'b0;
      settle_q <= `DSW_RST_SETTLE;
      wake_en_q <= 1'b0;
      wake_edge_q <= 1'b0;
      irq_mask_q <= 2'h0;
    end else if (wr_en) begin
      if (hit(req_q.addr, `DSW_IDX_PIN_SEL)) begin
        pin_sel_q <= HWDATA[`DSW_BIT_PIN_SEL];
      end
      if (hit(req_q.addr, `DSW_IDX_STBY_CTRL)) begin
        soft_stby_q <= HWDATA[`DSW_BIT_SOFT_STBY];
      end
      if (hit(req_q.addr, `DSW_IDX_DEEP_CTRL)) begin
        deep_stby_q <= HWDATA[`DSW_BIT_DEEP_STBY];
        port_hold_keep_q <= HWDATA[`DSW_BIT_PORT_HOLD];
      end
      if (hit(req_q.addr, `DSW_IDX_SETTLE)) begin
        settle_q <= HWDATA[5:0];
      end
      if (hit(req_q.addr, `DSW_IDX_WAKE_EN)) begin
        wake_en_q <= HWDATA[`DSW_BIT_WAKE_EN];
      end
      if (hit(req_q.addr, `DSW_IDX_WAKE_EDGE)) begin
        wake_edge_q <= HWDATA[`DSW_BIT_WAKE_EDGE];
      end
      if (hit(req_q.addr, `DSW_IDX_IRQ_MASK)) begin
        irq_mask_q <= HWDATA[1:0];
      end
    end
  end

  // Ratio register; the internal reset restores defaults so software
  // reprograms the clocks after every wake-up
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      clk_ratio_q <= `DSW_RST_CLK_RATIO;
    end else if (state_q == dsw_pkg::DSW_INTRST) begin
      clk_ratio_q <= `DSW_RST_CLK_RATIO;
    end else if (wr_en && hit(req_q.addr, `DSW_IDX_CLK_RATIO)) begin
      clk_ratio_q <= HWDATA[15:0];
      clk_ratio_q.rsv_hi <= 3'h0;
      clk_ratio_q.rsv_mid <= 1'b0;
      clk_ratio_q.rsv_lo <= 1'b0;
    end
  end

  // Two-stage synchronisers for both interrupt pins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync_a_q <= 2'b11;
      sync_b_q <= 2'b11;
    end else begin
      sync_a_q <= {sync_a_q[0], IRQ_PIN_A};
      sync_b_q <= {sync_b_q[0], IRQ_PIN_B};
    end
  end

  assign irq_sel = pin_sel_q ? sync_b_q[1] : sync_a_q[1];

  // Previous level of the selected input for edge detection
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_prev_q <= 1'b1;
    end else begin
      irq_prev_q <= irq_sel;
    end
  end

  // falling edge when select is 0, rising when 1
  assign edge_hit = wake_edge_q ? (irq_sel && !irq_prev_q) : (!irq_sel && irq_prev_q);
  assign wake_ev = (state_q == dsw_pkg::DSW_DEEP) && wake_en_q && edge_hit;
  assign enter_ev = (state_q == dsw_pkg::DSW_RUN) && SLEEP_REQ && soft_stby_q &&
                    deep_stby_q && !CANCEL_PENDING;

  // settle length from the code; long counts are parameters
  assign settle_len = (settle_q == `DSW_SETTLE_LONG_CODE) ? 18'(SETTLE_LONG - 1) :
                      18'(SETTLE_SHORT - 1);
  assign settle_done = (settle_cnt_q == settle_len);

  // Standby sequencer: deep standby, settle, internal reset, run
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= dsw_pkg::DSW_RUN;
      settle_cnt_q <= 18'h0_0000;
      intrst_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        dsw_pkg::DSW_RUN: begin
          if (enter_ev) begin
            state_q <= dsw_pkg::DSW_DEEP;
          end
        end
        dsw_pkg::DSW_DEEP: begin
          settle_cnt_q <= 18'h0_0000;
          if (wake_ev) begin
            state_q <= dsw_pkg::DSW_SETTLE;
          end
        end
        dsw_pkg::DSW_SETTLE: begin
          settle_cnt_q <= settle_cnt_q + 18'h0_0001;
          if (settle_done) begin
            state_q <= dsw_pkg::DSW_INTRST;
            intrst_cnt_q <= 4'h0;
          end
        end
        dsw_pkg::DSW_INTRST: begin
          intrst_cnt_q <= intrst_cnt_q + 4'h1;
          if (intrst_cnt_q == `DSW_INTRST_CYCLES - 4'h1) begin
            state_q <= dsw_pkg::DSW_RUN;
          end
        end
        default: state_q <= dsw_pkg::DSW_RUN;
      endcase
    end
  end

  // wake flag: set wins over clear; armed by a read that saw a one.
  // only the power-on reset touches it, not the internal reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wake_flag_q <= 1'b0;
      wake_flag_armed_q <= 1'b0;
    end else begin
      if (wake_ev) begin
        wake_flag_q <= 1'b1;
      end else if (wr_en && hit(req_q.addr, `DSW_IDX_WAKE_FLAGS) &&
                   !HWDATA[`DSW_BIT_WAKE_FLAG] && wake_flag_armed_q) begin
        wake_flag_q <= 1'b0;
      end
      if (rd_en && hit(req_q.addr, `DSW_IDX_WAKE_FLAGS) && wake_flag_q) begin
        wake_flag_armed_q <= 1'b1;
      end else if (wr_en && hit(req_q.addr, `DSW_IDX_WAKE_FLAGS)) begin
        wake_flag_armed_q <= 1'b0;
      end
    end
  end

  // reset cause flag, set when the internal reset starts
  // it too survives the internal reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rst_flag_q <= 1'b0;
      rst_flag_armed_q <= 1'b0;
    end else begin
      if (state_q == dsw_pkg::DSW_SETTLE && settle_done) begin
        rst_flag_q <= 1'b1;
      end else if (wr_en && hit(req_q.addr, `DSW_IDX_RST_CAUSE) &&
                   !HWDATA[`DSW_BIT_RST_FLAG] && rst_flag_armed_q) begin
        rst_flag_q <= 1'b0;
      end
      if (rd_en && hit(req_q.addr, `DSW_IDX_RST_CAUSE) && rst_flag_q) begin
        rst_flag_armed_q <= 1'b1;
      end else if (wr_en && hit(req_q.addr, `DSW_IDX_RST_CAUSE)) begin
        rst_flag_armed_q <= 1'b0;
      end
    end
  end

  // Sticky interrupt status, write one to clear; a new event wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_stat_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      if (wr_en && hit(req_q.addr, `DSW_IDX_IRQ_STATUS)) begin
        irq_stat_q <= (irq_stat_q & ~HWDATA[1:0]) | {enter_ev, wake_ev};
      end else begin
        irq_stat_q <= irq_stat_q | {enter_ev, wake_ev};
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Port retention: capture at entry, drive held value while holding
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hold_q <= 1'b0;
      hold_val_q <= '0;
      port_out_q <= '0;
    end else begin
      if (enter_ev) begin
        hold_q <= 1'b1;
        hold_val_q <= PORT_IN;
      end else if (wake_ev && !port_hold_keep_q) begin
        hold_q <= 1'b0;
      end else if (state_q == dsw_pkg::DSW_RUN && wr_en &&
                   hit(req_q.addr, `DSW_IDX_DEEP_CTRL) && !HWDATA[`DSW_BIT_PORT_HOLD]) begin
        // Kept states end when software clears the hold bit after exit
        hold_q <= 1'b0;
      end
      port_out_q <= (hold_q || enter_ev) ? (enter_ev ? PORT_IN : hold_val_q) : PORT_IN;
    end
  end

  // Clock pins; stopped high while the oscillator is down or settling,
  // which keeps the unstable period off the pins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      clk_div_q <= 1'b0;
      bus_pin_q <= 1'b1;
      sdram_pin_q <= 1'b1;
    end else begin
      clk_div_q <= ~clk_div_q;
      bus_pin_q <= (clk_ratio_q.bus_clk_pin_gate || state_q != dsw_pkg::DSW_RUN) ?
                   1'b1 : clk_div_q;
      sdram_pin_q <= (clk_ratio_q.sdram_clk_pin_gate || state_q != dsw_pkg::DSW_RUN) ?
                     1'b1 : clk_div_q;
    end
  end

  // Clock ratio outputs and status levels
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      core_mult_q <= 3'h0;
      periph_mult_q <= 3'h0;
      extbus_mult_q <= 3'h0;
      deep_out_q <= 1'b0;
      intrst_out_q <= 1'b0;
    end else begin
      core_mult_q <= ratio_mult(clk_ratio_q.core_clk_ratio);
      periph_mult_q <= ratio_mult(clk_ratio_q.periph_clk_ratio);
      extbus_mult_q <= ratio_mult(clk_ratio_q.extbus_clk_ratio);
      deep_out_q <= (state_q == dsw_pkg::DSW_DEEP) || (state_q == dsw_pkg::DSW_SETTLE);
      intrst_out_q <= (state_q == dsw_pkg::DSW_INTRST);
    end
  end

  assign HRDATA = rdata_q;
  assign HREADYOUT = hready_q;
  assign HRESP = 1'b0;
  assign PORT_OUT = port_out_q;
  assign PORT_HOLD = hold_q;
  assign DEEP_STANDBY = deep_out_q;
  assign INT_RESET = intrst_out_q;
  assign BUS_CLK_PIN = bus_pin_q;
  assign SDRAM_CLK_PIN = sdram_pin_q;
  assign CORE_CLK_MULT = core_mult_q;
  assign PERIPH_CLK_MULT = periph_mult_q;
  assign EXTBUS_CLK_MULT = extbus_mult_q;
  assign IRQ = irq_q;

endmodule : dsw_top

`default_nettype wire

// ==== dv/dsw_top_properties.sv ====
// Concurrent checks of the deep standby wake-up controller.
// Assumes it is bound into dsw_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module dsw_top_chk #(
  parameter int PORT_W = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic SLEEP_REQ,
  input wire logic CANCEL_PENDING,
  input wire logic [PORT_W-1:0] PORT_OUT,
  input wire logic PORT_HOLD,
  input wire logic DEEP_STANDBY,
  input wire logic INT_RESET,
  input wire logic BUS_CLK_PIN,
  input wire logic SDRAM_CLK_PIN,
  input wire logic [2:0] CORE_CLK_MULT,
  input wire logic [2:0] PERIPH_CLK_MULT,
  input wire logic [2:0] EXTBUS_CLK_MULT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // One wait state, then ready again
  sequence s_wait_state;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  // Internal reset lasts exactly four cycles
  sequence s_int_pulse;
    INT_RESET [*4] ##1 !INT_RESET;
  endsequence

  // Bus handshake: every accepted address gets one wait state
  a_bus_wait_state: assert property (HSEL && HTRANS[1] && HREADY |=> s_wait_state)
    else $error("transfer without its single wait state");
  a_resp_always_okay: assert property (HRESP == 1'b0)
    else $error("error response seen");
  // The status level lags the entry edge by two edges: state, then output
  a_deep_entry_cause: assert property ($rose(DEEP_STANDBY) |-> $past(SLEEP_REQ, 2) && !$past(CANCEL_PENDING, 2))
    else $error("deep standby entered without a clean sleep request");
  a_hold_on_entry: assert property ($rose(DEEP_STANDBY) |-> PORT_HOLD)
    else $error("ports not held on deep standby entry");
  // Held ports must not move, whatever the live pins do
  a_port_frozen: assert property (PORT_HOLD && $past(PORT_HOLD) |-> $stable(PORT_OUT))
    else $error("port output moved while held");
  a_int_reset_len: assert property ($rose(INT_RESET) |-> s_int_pulse)
    else $error("internal reset not four cycles long");
  a_exit_on_reset: assert property ($rose(INT_RESET) |-> $fell(DEEP_STANDBY))
    else $error("deep standby not left as internal reset starts");
  // Even the short settle count keeps the core asleep sixteen cycles
  a_settle_min: assert property ($rose(INT_RESET) |-> $past(DEEP_STANDBY, 16))
    else $error("settle wait too short");
  a_clk_pins_quiet: assert property (DEEP_STANDBY && $past(DEEP_STANDBY) |-> BUS_CLK_PIN && SDRAM_CLK_PIN)
    else $error("clock pins toggling in deep standby");
  a_ratio_restore: assert property ($fell(INT_RESET) |-> CORE_CLK_MULT == 3'h4 && PERIPH_CLK_MULT == 3'h2 && EXTBUS_CLK_MULT == 3'h4)
    else $error("clock ratios not restored by internal reset");
endmodule : dsw_top_chk

bind dsw_top dsw_top_chk #(.PORT_W(PORT_W)) chk (.CLK(CLK), .RST(RST), .HSEL(HSEL),
  .HTRANS(HTRANS), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .SLEEP_REQ(SLEEP_REQ), .CANCEL_PENDING(CANCEL_PENDING), .PORT_OUT(PORT_OUT),
  .PORT_HOLD(PORT_HOLD), .DEEP_STANDBY(DEEP_STANDBY), .INT_RESET(INT_RESET),
  .BUS_CLK_PIN(BUS_CLK_PIN), .SDRAM_CLK_PIN(SDRAM_CLK_PIN), .CORE_CLK_MULT(CORE_CLK_MULT),
  .PERIPH_CLK_MULT(PERIPH_CLK_MULT), .EXTBUS_CLK_MULT(EXTBUS_CLK_MULT));

`default_nettype wire

// ==== dv/dsw_irq_src.sv ====
// Wake interrupt source driving the controller's two interrupt pins.
// Assumes the bench calls set_pins right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module dsw_irq_src (
  input wire logic clk,
  output var logic pin_a,
  output var logic pin_b
);
  // Lines idle high so that a wake-up is a falling edge
  initial begin
    pin_a = 1'b1;
    pin_b = 1'b1;
  end

  // Levels change just after an edge, never on it
  task automatic set_pins(input logic a, input logic b);
    @(posedge clk);
    pin_a <= a;
    pin_b <= b;
  endtask : set_pins
endmodule : dsw_irq_src

`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench of the deep standby wake-up controller.
// Assumes the design files and the constants header compile first.
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defines.svh"

module testbench;
  localparam int SL = 64;
  localparam int SS = 16;
  logic CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, SLEEP_REQ, CANCEL_PENDING;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS, s1, s2;
  logic [2:0] HSIZE, CORE_CLK_MULT, PERIPH_CLK_MULT, EXTBUS_CLK_MULT;
  logic [7:0] PORT_IN, PORT_OUT;
  logic PORT_HOLD, DEEP_STANDBY, INT_RESET, BUS_CLK_PIN, SDRAM_CLK_PIN, IRQ, pin_a, pin_b;
  int err_total, comparisons, n;

  dsw_top #(.PORT_W(8), .SETTLE_LONG(SL), .SETTLE_SHORT(SS)) dut (.CLK(CLK), .RST(RST),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .IRQ_PIN_A(pin_a), .IRQ_PIN_B(pin_b), .SLEEP_REQ(SLEEP_REQ),
    .CANCEL_PENDING(CANCEL_PENDING), .PORT_IN(PORT_IN), .PORT_OUT(PORT_OUT),
    .PORT_HOLD(PORT_HOLD), .DEEP_STANDBY(DEEP_STANDBY), .INT_RESET(INT_RESET),
    .BUS_CLK_PIN(BUS_CLK_PIN), .SDRAM_CLK_PIN(SDRAM_CLK_PIN), .CORE_CLK_MULT(CORE_CLK_MULT),
    .PERIPH_CLK_MULT(PERIPH_CLK_MULT), .EXTBUS_CLK_MULT(EXTBUS_CLK_MULT), .IRQ(IRQ));

  dsw_irq_src src (.clk(CLK), .pin_a(pin_a), .pin_b(pin_b));

  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Single word transfer; address held until ready is sampled high
  task automatic xfer(input logic [23:0] idx, input logic wr_en, input logic [31:0] wd);
    HSEL <= 1'b1;
    HADDR <= 32'({idx, 2'b00});
    HWRITE <= wr_en;
    HTRANS <= 2'b10;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    rd = HRDATA;
  endtask : xfer

  task automatic wr(input logic [23:0] idx, input logic [31:0] d);
    xfer(idx, 1'b1, d);
  endtask : wr

  task automatic rc(input logic [23:0] idx, input logic [31:0] e);
    xfer(idx, 1'b0, 32'h0);
    chk(rd, e);
  endtask : rc

  // Sleep pulse; the standby level shows two edges after the entry edge
  task automatic sleep_pulse(input logic cancel);
    SLEEP_REQ <= 1'b1;
    CANCEL_PENDING <= cancel;
    @(posedge CLK);
    SLEEP_REQ <= 1'b0;
    CANCEL_PENDING <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : sleep_pulse

  // Bounded wait for the internal reset, counting edges
  task automatic wait_rst;
    n = 0;
    while (INT_RESET !== 1'b1 && n < 400) begin
      @(posedge CLK);
      n++;
    end
  endtask : wait_rst

  function automatic logic [31:0] exp_mult(input int c);
    return (c == 0) ? 32'h4 : (c == 1) ? 32'h2 : (c == 2) ? 32'h1 : 32'h0;
  endfunction : exp_mult

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    results();
  end

  initial begin
    {HSEL, HWRITE, SLEEP_REQ, CANCEL_PENDING} = 4'h0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    PORT_IN = 8'h5a;
    err_total = 0;
    comparisons = 0;
    RST = 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rc(`DSW_IDX_CLK_RATIO, 32'h10);
    rc(`DSW_IDX_SETTLE, 32'h0d);
    rc(24'h000123, 32'h0);
    // Ratio codes 0 to 3, with the two pin gates walked alongside
    for (int c = 0; c < 4; c++) begin
      wr(`DSW_IDX_CLK_RATIO, 32'({c[1:0], 3'h0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]}));
      repeat (2) @(posedge CLK);
      chk(32'(CORE_CLK_MULT), exp_mult(c));
      chk(32'(PERIPH_CLK_MULT), exp_mult(c));
      chk(32'(EXTBUS_CLK_MULT), exp_mult(c));
      s1 = {BUS_CLK_PIN, SDRAM_CLK_PIN};
      @(posedge CLK);
      s2 = {BUS_CLK_PIN, SDRAM_CLK_PIN};
      chk(32'(c[1] ? s1[1] & s2[1] : s1[1] ^ s2[1]), 32'h1);
      chk(32'(c[0] ? s1[0] & s2[0] : s1[0] ^ s2[0]), 32'h1);
    end
    $display("test clocks done");
    wr(`DSW_IDX_PIN_SEL, 32'h0);
    wr(`DSW_IDX_WAKE_EDGE, 32'h0);
    wr(`DSW_IDX_WAKE_EN, 32'h0);
    wr(`DSW_IDX_IRQ_MASK, 32'h0);
    wr(`DSW_IDX_STBY_CTRL, 32'h8000);
    wr(`DSW_IDX_DEEP_CTRL, 32'h80);
    sleep_pulse(1'b1);
    chk(32'(DEEP_STANDBY), 32'h0);
    sleep_pulse(1'b0);
    chk(32'({DEEP_STANDBY, PORT_HOLD}), 32'h3);
    PORT_IN <= 8'ha5;
    repeat (3) @(posedge CLK);
    chk(32'(PORT_OUT), 32'h5a);
    // Falling edge while disabled, then rising edge and wrong pin while
    // enabled: none may set the flag, which the long settle would hide
    src.set_pins(1'b0, 1'b1);
    repeat (10) @(posedge CLK);
    chk(32'(DEEP_STANDBY), 32'h1);
    rc(`DSW_IDX_WAKE_FLAGS, 32'h0);
    wr(`DSW_IDX_WAKE_EN, 32'h1);
    src.set_pins(1'b1, 1'b0);
    repeat (10) @(posedge CLK);
    chk(32'(DEEP_STANDBY), 32'h1);
    rc(`DSW_IDX_WAKE_FLAGS, 32'h0);
    src.set_pins(1'b0, 1'b1);
    wait_rst();
    chk(32'(n >= SL && n <= SL + 8), 32'h1);
    chk(32'({DEEP_STANDBY, PORT_HOLD}), 32'h0);
    src.set_pins(1'b1, 1'b1);
    repeat (6) @(posedge CLK);
    chk(32'(PORT_OUT), 32'ha5);
    rc(`DSW_IDX_CLK_RATIO, 32'h10);
    chk(32'(IRQ), 32'h0);
    rc(`DSW_IDX_IRQ_STATUS, 32'h3);
    wr(`DSW_IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge CLK);
    chk(32'(IRQ), 32'h1);
    wr(`DSW_IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge CLK);
    chk(32'(IRQ), 32'h0);
    // A zero written before a read that saw the flag set must not clear it
    wr(`DSW_IDX_WAKE_FLAGS, 32'h0);
    rc(`DSW_IDX_WAKE_FLAGS, 32'h1);
    wr(`DSW_IDX_WAKE_FLAGS, 32'h0);
    rc(`DSW_IDX_WAKE_FLAGS, 32'h0);
    wr(`DSW_IDX_RST_CAUSE, 32'h0);
    rc(`DSW_IDX_RST_CAUSE, 32'h80);
    wr(`DSW_IDX_RST_CAUSE, 32'h0);
    rc(`DSW_IDX_RST_CAUSE, 32'h0);
    $display("test wake long done");
    wr(`DSW_IDX_PIN_SEL, 32'h1);
    wr(`DSW_IDX_SETTLE, 32'h1);
    wr(`DSW_IDX_DEEP_CTRL, 32'hc0);
    sleep_pulse(1'b0);
    chk(32'(DEEP_STANDBY), 32'h1);
    src.set_pins(1'b1, 1'b0);
    wait_rst();
    chk(32'(n >= SS && n <= SS + 8), 32'h1);
    src.set_pins(1'b1, 1'b1);
    repeat (6) @(posedge CLK);
    chk(32'(PORT_HOLD), 32'h1);
    wr(`DSW_IDX_DEEP_CTRL, 32'h0);
    repeat (2) @(posedge CLK);
    chk(32'(PORT_HOLD), 32'h0);
    $display("test wake short done");
    results();
  end
endmodule : testbench

`default_nettype wire
